// File: core/teleprinter_pkg.sv
// constants and carrier types for the teleprinter control logic
package teleprinter_pkg;

  localparam int CHAR_W = 6;
  localparam int WORD_W = 15;
  localparam int REG_AW = 2;
  localparam int REG_DW = 8;

  // typewriter movement codes and two letter codes, same in either case
  localparam logic [5:0] MV_TAPE_FEED = 6'h00;
  localparam logic [5:0] MV_COLOR_SHIFT = 6'h02;
  localparam logic [5:0] MV_SPACE = 6'h04;
  localparam logic [5:0] MV_STOP_READ = 6'h23;
  localparam logic [5:0] MV_CR_LF = 6'h25;
  localparam logic [5:0] MV_SHIFT_UP = 6'h27;
  localparam logic [5:0] MV_TAB = 6'h29;
  localparam logic [5:0] MV_SHIFT_DOWN = 6'h2F;
  localparam logic [5:0] MV_BACKSPACE = 6'h31;
  localparam logic [5:0] MV_CODE_DELETE = 6'h3F;
  localparam logic [5:0] CH_LETTER_A = 6'h18;
  localparam logic [5:0] CH_LETTER_B = 6'h13;

  // function codes carried with the external-function qualifier
  localparam logic [5:0] FN_FAULT = 6'h01;
  localparam logic [5:0] FN_MASTER_CLEAR = 6'h08;
  localparam logic [5:0] FN_ENABLE_OUTPUT = 6'h02;
  localparam logic [5:0] FN_DISABLE_OUTPUT = 6'h03;
  localparam logic [5:0] FN_ENABLE_INPUT = 6'h04;
  localparam logic [5:0] FN_DISABLE_INPUT = 6'h05;

  // register indices on the software port
  localparam logic [REG_AW-1:0] REG_STATUS = 2'h0;
  localparam logic [REG_AW-1:0] REG_IN_CHAR = 2'h1;
  localparam logic [REG_AW-1:0] REG_CTRL = 2'h2;

  // status field positions
  localparam int ST_INPUT = 0;
  localparam int ST_OUTPUT = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_UPPER = 3;
  localparam int ST_ONLINE = 4;
  localparam int ST_IN_FULL = 5;
  localparam int ST_READ_STOP = 6;
  localparam int ST_MOTOR_REQ = 7;

  localparam int CTRL_PUNCH = 0;
  localparam logic [REG_DW-1:0] CTRL_RESET = 8'h00;

  // panel pushbutton positions
  localparam int BTN_INPUT = 0;
  localparam int BTN_INPUT_CLR = 1;
  localparam int BTN_OUTPUT = 2;
  localparam int BTN_OUTPUT_CLR = 3;
  localparam int BTN_FAULT_CLR = 4;
  localparam int BTN_MASTER_CLR = 5;
  localparam int BTN_COUNT = 6;

  typedef struct packed {
    logic strobe;
    logic ext_func;
    logic [WORD_W-1:0] word;
  } chan_word_t;

  typedef struct packed {
    logic print;
    logic upper;
    logic carriage_return;
    logic space;
    logic tab;
    logic backspace;
    logic shift_up;
    logic shift_down;
    logic tape_feed;
    logic code_delete;
    logic stop_read;
    logic color_shift;
    logic [CHAR_W-1:0] code;
  } action_t;

endpackage

// File: core/press_detect.sv
// rising-edge pulses for the panel pushbuttons
`timescale 1ns/1ps
`default_nettype none
module press_detect import teleprinter_pkg::*; #(
  parameter int W = BTN_COUNT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] btn,
  output logic [W-1:0] press
);
  logic [W-1:0] prev_q;
  logic [W-1:0] press_q;
  wire logic [W-1:0] press_d = btn & ~prev_q;

  // a held button acts once, not every cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= '0;
      press_q <= '0;
    end else if (clk_en) begin
      prev_q <= btn;
      press_q <= press_d;
    end
  end

  assign press = press_q;
endmodule // press_detect
`default_nettype wire

// File: core/char_decoder.sv
// registered decode of a six-bit code into one typewriter action
`timescale 1ns/1ps
`default_nettype none
module char_decoder import teleprinter_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic take,
  input wire logic [CHAR_W-1:0] code,
  input wire logic upper,
  output action_t action
);
  action_t act_q;
  action_t act_d;

  wire logic is_move = (code == MV_TAPE_FEED) || (code == MV_COLOR_SHIFT) ||
    (code == MV_SPACE) || (code == MV_STOP_READ) || (code == MV_CR_LF) ||
    (code == MV_SHIFT_UP) || (code == MV_TAB) || (code == MV_SHIFT_DOWN) ||
    (code == MV_BACKSPACE) || (code == MV_CODE_DELETE);

  always_comb begin
    act_d = '0;
    if (take) begin
      act_d.code = code;
      act_d.print = !is_move;
      act_d.upper = upper;
      act_d.carriage_return = (code == MV_CR_LF);
      act_d.shift_up = (code == MV_SHIFT_UP);
      act_d.shift_down = (code == MV_SHIFT_DOWN);
      act_d.tape_feed = (code == MV_TAPE_FEED);
      act_d.tab = (code == MV_TAB);
      act_d.backspace = (code == MV_BACKSPACE);
      act_d.code_delete = (code == MV_CODE_DELETE);
      act_d.space = (code == MV_SPACE);
      act_d.stop_read = (code == MV_STOP_READ);
      act_d.color_shift = (code == MV_COLOR_SHIFT);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_q <= '0;
    end else if (clk_en) begin
      act_q <= act_d;
    end
  end

  assign action = act_q;
endmodule // char_decoder
`default_nettype wire

// File: core/teleprinter_control.sv
// teleprinter control: channel zero functions, modes, panel and relays
// Operation
// - the attachment never raises an interrupt or sends a status report
// - in output mode a code drives its action: 45 return, 30 prints A
// - letters share one code for both cases; shift state picks the case
// - 47 shifts up, 57 shifts down, 00 feeds tape without printing
// - 51 tabs, 61 backspaces, 77 deletes, 04 spaces, 43 stops reading
// - input mode from computer or pushbutton lights the input lamp
// - clear button under input button resets input mode
// - output mode from computer or pushbutton lights the output lamp
// - clear button under output button resets output mode
// - function 01 only sets the fault flag and lamp
// - fault clear button resets the fault flag without the computer
// - function 10 or master clear button clears modes, fault, shift case and input flags; ctrl register kept
// - manual operation keeps typewriter working, computer control disabled
// - off-line: motor power on, logic motor request held inactive
// - off-line: reader clutch path enabled and ready lamp lit
// - on-line: motor and reader governed only by logic and computer
// - on-line: motor runs only while a motor request is active
// - on-line input: reader clutch driven by input-mode logic
// - function words need the qualifier; others are data
// - characters ride on the six lowest bits of the word
`timescale 1ns/1ps
`default_nettype none
module teleprinter_control import teleprinter_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire chan_word_t chan,
  output logic chan_ack,
  input wire logic online_switch_contacts,
  input wire logic [BTN_COUNT-1:0] panel_btn,
  input wire logic tw_busy,
  input wire logic tw_in_valid,
  input wire logic [CHAR_W-1:0] tw_in_code,
  output action_t tw_action,
  output logic motor_power_relay,
  output logic motor_request,
  output logic reader_enable_relay,
  output logic ready_lamp,
  output logic input_lamp,
  output logic output_lamp,
  output logic fault_lamp,
  output logic punch_enable,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata
);
  // no interrupt or status-report path exists on this channel

  logic in_mode_q;
  logic in_mode_d;
  logic out_mode_q;
  logic out_mode_d;
  logic fault_q;
  logic fault_d;
  logic upper_q;
  logic upper_d;
  logic in_full_q;
  logic in_full_d;
  logic read_stop_q;
  logic read_stop_d;
  logic [CHAR_W-1:0] in_char_q;
  logic [REG_DW-1:0] ctrl_q;
  logic [REG_DW-1:0] rdata_q;
  logic [REG_DW-1:0] rdata_d;
  logic [REG_DW-1:0] status_w;
  logic ack_q;
  logic motor_req_q;
  logic motor_pwr_q;
  logic reader_q;
  logic ready_q;
  logic punch_q;
  logic [BTN_COUNT-1:0] press;

  press_detect #(.W(BTN_COUNT)) u_press (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .btn(panel_btn),
    .press(press)
  );

  // contacts closed means manual, off-line use
  wire logic offline = online_switch_contacts;
  wire logic online = !offline;

  // the computer reaches nothing while off-line
  wire logic word_in = clk_en && online && chan.strobe;
  wire logic fn_take = word_in && chan.ext_func;
  wire logic [CHAR_W-1:0] fn_code = chan.word[CHAR_W-1:0];
  wire logic [CHAR_W-1:0] data_code = chan.word[CHAR_W-1:0];
  wire logic data_take = word_in && !chan.ext_func && out_mode_q;

  wire logic fn_fault = fn_take && (fn_code == FN_FAULT);
  wire logic fn_mclr = fn_take && (fn_code == FN_MASTER_CLEAR);
  wire logic fn_en_out = fn_take && (fn_code == FN_ENABLE_OUTPUT);
  wire logic fn_dis_out = fn_take && (fn_code == FN_DISABLE_OUTPUT);
  wire logic fn_en_in = fn_take && (fn_code == FN_ENABLE_INPUT);
  wire logic fn_dis_in = fn_take && (fn_code == FN_DISABLE_INPUT);
  // any other code decodes to none of the strobes above
  wire logic fn_unknown = fn_take && !(fn_fault || fn_mclr || fn_en_out ||
    fn_dis_out || fn_en_in || fn_dis_in);

  // panel presses act only on clock-enabled cycles
  wire logic [BTN_COUNT-1:0] pb = press & {BTN_COUNT{clk_en}};
  wire logic mclr = fn_mclr || pb[BTN_MASTER_CLR];

  // mode changes: output wins a tie so the modes stay exclusive
  wire logic set_out = fn_en_out || pb[BTN_OUTPUT];
  wire logic set_in = (fn_en_in || pb[BTN_INPUT]) && !set_out;
  wire logic clr_out = mclr || fn_dis_out || pb[BTN_OUTPUT_CLR] || set_in;
  wire logic clr_in = mclr || fn_dis_in || pb[BTN_INPUT_CLR] || set_out;

  // fault: an incoming code beats a clear in the same cycle
  wire logic set_fault = fn_fault;
  wire logic clr_fault = mclr || pb[BTN_FAULT_CLR];

  wire logic shift_up = data_take && (data_code == MV_SHIFT_UP);
  wire logic shift_dn = data_take && (data_code == MV_SHIFT_DOWN);

  // characters read from tape while in input mode
  wire logic in_take = clk_en && online && in_mode_q && tw_in_valid &&
    !read_stop_q;
  wire logic in_stop = in_take && (tw_in_code == MV_STOP_READ);
  wire logic in_read = clk_en && reg_rd && (reg_addr == REG_IN_CHAR);

  // three requests: input mode, output mode, mechanism busy
  wire logic req_d = online && (in_mode_q || out_mode_q || tw_busy);
  wire logic pwr_d = offline || req_d;
  wire logic reader_d = offline || (in_mode_q && !read_stop_q);

  wire logic ctrl_wr = clk_en && reg_wr && (reg_addr == REG_CTRL);

  always_comb begin
    in_mode_d = in_mode_q;
    if (set_in) begin
      in_mode_d = 1'b1;
    end else if (clr_in) begin
      in_mode_d = 1'b0;
    end
    out_mode_d = out_mode_q;
    if (set_out) begin
      out_mode_d = 1'b1;
    end else if (clr_out) begin
      out_mode_d = 1'b0;
    end
    fault_d = fault_q;
    if (set_fault) begin
      fault_d = 1'b1;
    end else if (clr_fault) begin
      fault_d = 1'b0;
    end
    upper_d = upper_q;
    if (mclr || shift_dn) begin
      upper_d = 1'b0;
    end else if (shift_up) begin
      upper_d = 1'b1;
    end
    in_full_d = in_full_q;
    if (in_take) begin
      in_full_d = 1'b1;
    end else if (in_read || mclr) begin
      in_full_d = 1'b0;
    end
    read_stop_d = read_stop_q;
    if (in_stop) begin
      read_stop_d = 1'b1;
    end else if (mclr || set_in) begin
      read_stop_d = 1'b0;
    end
  end

  always_comb begin
    status_w = '0;
    status_w[ST_INPUT] = in_mode_q;
    status_w[ST_OUTPUT] = out_mode_q;
    status_w[ST_FAULT] = fault_q;
    status_w[ST_UPPER] = upper_q;
    status_w[ST_ONLINE] = online;
    status_w[ST_IN_FULL] = in_full_q;
    status_w[ST_READ_STOP] = read_stop_q;
    status_w[ST_MOTOR_REQ] = motor_req_q;
  end

  // unmapped reads answer zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: rdata_d = status_w;
        REG_IN_CHAR: rdata_d = {{(REG_DW-CHAR_W){1'b0}}, in_char_q};
        REG_CTRL: rdata_d = ctrl_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_mode_q <= 1'b0;
      out_mode_q <= 1'b0;
      fault_q <= 1'b0;
      upper_q <= 1'b0;
      in_full_q <= 1'b0;
      read_stop_q <= 1'b0;
    end else if (clk_en) begin
      in_mode_q <= in_mode_d;
      out_mode_q <= out_mode_d;
      fault_q <= fault_d;
      upper_q <= upper_d;
      in_full_q <= in_full_d;
      read_stop_q <= read_stop_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_char_q <= '0;
    end else if (in_take) begin
      in_char_q <= tw_in_code;
    end
  end

  // ctrl is software's, so master clear leaves it alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
      ack_q <= fn_take || data_take;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      motor_req_q <= 1'b0;
      motor_pwr_q <= 1'b0;
      reader_q <= 1'b0;
      ready_q <= 1'b0;
      punch_q <= 1'b0;
    end else if (clk_en) begin
      motor_req_q <= req_d;
      motor_pwr_q <= pwr_d;
      reader_q <= reader_d;
      ready_q <= offline;
      punch_q <= online && out_mode_d && ctrl_q[CTRL_PUNCH];
    end
  end

  char_decoder u_dec (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .take(data_take),
    .code(data_code),
    .upper(upper_q),
    .action(tw_action)
  );

  assign chan_ack = ack_q;
  assign motor_power_relay = motor_pwr_q;
  assign motor_request = motor_req_q;
  assign reader_enable_relay = reader_q;
  assign ready_lamp = ready_q;
  assign input_lamp = in_mode_q;
  assign output_lamp = out_mode_q;
  assign fault_lamp = fault_q;
  assign punch_enable = punch_q;
  assign reg_rdata = rdata_q;

  // checks
  sequence s_fn(logic [CHAR_W-1:0] c);
    fn_take && (fn_code == c);
  endsequence

  sequence s_char(logic [CHAR_W-1:0] c);
    data_take && (data_code == c);
  endsequence

  AST_FAULT_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_fn(FN_FAULT) |=> fault_lamp && $stable(input_lamp) && $stable(output_lamp))
    else $error("fault code did not set fault alone");

  AST_FAULT_CLR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && pb[BTN_FAULT_CLR] && !fn_fault |=> !fault_lamp)
    else $error("fault clear button ignored");

  AST_MASTER_CLR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_fn(FN_MASTER_CLEAR) && !pb[BTN_INPUT] && !pb[BTN_OUTPUT]
    |=> !input_lamp && !output_lamp && !fault_lamp)
    else $error("master clear left state set");

  AST_IN_LAMP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_fn(FN_ENABLE_INPUT) && !pb[BTN_OUTPUT] |=> input_lamp && !output_lamp)
    else $error("input mode not lit");

  AST_OUT_LAMP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_fn(FN_ENABLE_OUTPUT) |=> output_lamp && !input_lamp)
    else $error("output mode not lit");

  AST_CR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_char(MV_CR_LF) |=> tw_action.carriage_return && !tw_action.print)
    else $error("return code gave no return");

  AST_SHIFT_CASE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_char(MV_SHIFT_UP) ##1 !data_take ##1 s_char(CH_LETTER_B)
    |=> tw_action.print && tw_action.upper)
    else $error("letter after shift up not upper case");

  AST_OFFLINE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && offline |=> motor_power_relay && !motor_request)
    else $error("off-line motor wrong");

  AST_OFFLINE_RDR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && offline |=> reader_enable_relay && ready_lamp)
    else $error("off-line reader path not enabled");

  AST_NO_CTRL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && offline |=> !chan_ack)
    else $error("computer word taken while off-line");

  AST_MOTOR_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && online && !input_lamp && !output_lamp && !tw_busy |=> !motor_power_relay)
    else $error("motor on with no request");

  AST_UNKNOWN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fn_unknown && (pb == '0) |=> $stable(input_lamp) && $stable(output_lamp)
    && $stable(fault_lamp))
    else $error("unknown function changed state");

  AST_READER_IN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && online && in_mode_q && !read_stop_q |=> reader_enable_relay)
    else $error("reader clutch not driven in input mode");
endmodule // teleprinter_control
`default_nettype wire

// File: bench/chan_model.sv
// channel zero model: the computer side issuing words to the block
`timescale 1ns/1ps
`default_nettype none
module chan_model import teleprinter_pkg::*; (
  input wire logic clk_sys,
  input wire logic chan_ack,
  output chan_word_t chan
);
  initial begin
    chan = '0;
  end
  // lines show the inverse once the strobe drops, so stale data is never taken
  task automatic send(input logic ef, input logic [5:0] code, output logic acked);
    @(posedge clk_sys);
    chan.strobe <= 1'b1;
    chan.ext_func <= ef;
    chan.word <= {9'h000, code};
    @(posedge clk_sys);
    chan.strobe <= 1'b0;
    chan.ext_func <= ~ef;
    chan.word <= ~{9'h000, code};
    #1;
    acked = chan_ack;
  endtask
endmodule // chan_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the teleprinter control logic
`timescale 1ns/1ps
`default_nettype none
module tb_top import teleprinter_pkg::*; ();
  logic clk_sys, reset_n, clk_en, online_switch_contacts, tw_busy, tw_in_valid, reg_wr, reg_rd;
  logic [BTN_COUNT-1:0] panel_btn;
  logic [CHAR_W-1:0] tw_in_code;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata, rv;
  chan_word_t chan;
  action_t tw_action;
  logic chan_ack, motor_power_relay, motor_request, reader_enable_relay, ready_lamp;
  logic input_lamp, output_lamp, fault_lamp, punch_enable, ak;
  int n_fail, checks_done;
  wire logic [17:0] st = {10'h000, punch_enable, ready_lamp, motor_power_relay, motor_request,
    reader_enable_relay, fault_lamp, output_lamp, input_lamp};
  // {print, upper, movement flags, code}; upper is only judged on printing codes
  localparam logic [17:0] ACT_TBL [13] = '{18'h08025, 18'h20018, 18'h00827, 18'h30013,
    18'h0042F, 18'h20013, 18'h00200, 18'h02029, 18'h01031, 18'h0013F, 18'h04004,
    18'h000A3, 18'h00042};

  teleprinter_control teleprinter_control_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .chan(chan), .chan_ack(chan_ack),
    .online_switch_contacts(online_switch_contacts), .panel_btn(panel_btn),
    .tw_busy(tw_busy), .tw_in_valid(tw_in_valid), .tw_in_code(tw_in_code),
    .tw_action(tw_action), .motor_power_relay(motor_power_relay),
    .motor_request(motor_request), .reader_enable_relay(reader_enable_relay),
    .ready_lamp(ready_lamp), .input_lamp(input_lamp), .output_lamp(output_lamp),
    .fault_lamp(fault_lamp), .punch_enable(punch_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  chan_model chan_model_inst (.clk_sys(clk_sys), .chan_ack(chan_ack), .chan(chan));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic word(input logic ef, input logic [5:0] c, input logic exp_ack);
    chan_model_inst.send(ef, c, ak);
    chk("chan_ack", {17'h00000, exp_ack}, {17'h00000, ak});
  endtask

  // held button must act once; lamp settles two cycles after the rise
  task automatic push(input int i);
    @(posedge clk_sys);
    panel_btn[i] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    panel_btn[i] <= 1'b0;
    #1;
  endtask

  task automatic feed(input logic [5:0] c);
    @(posedge clk_sys);
    tw_in_valid <= 1'b1;
    tw_in_code <= c;
    @(posedge clk_sys);
    tw_in_valid <= 1'b0;
    tw_in_code <= ~c;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic s_output;
    logic [17:0] msk;
    word(1'b1, FN_ENABLE_OUTPUT, 1'b1);
    chk("lamps", 18'h00002, st & 18'h00007);
    tick(1);
    chk("relays", 18'h00032, st & 18'h0007F);
    for (int i = 0; i < 13; i++) begin
      word(1'b0, ACT_TBL[i][5:0], 1'b1);
      msk = ACT_TBL[i][17] ? 18'h3FFFF : 18'h2FFFF;
      chk("tw_action", ACT_TBL[i], 18'(tw_action) & msk);
    end
    tick(1);
    chk("action idle", 18'h00000, 18'(tw_action));
    word(1'b0, FN_FAULT, 1'b1);
    chk("fault as data", 18'h00000, st & 18'h00004);
    reg_write(REG_CTRL, 8'h01);
    reg_write(REG_STATUS, 8'hFF);
    tick(1);
    chk("punch", 18'h00080, st & 18'h00080);
    reg_read(REG_CTRL, rv);
    chk("ctrl", 18'h00001, 18'(rv));
    reg_read(2'h3, rv);
    chk("unmapped", 18'h00000, 18'(rv));
    reg_read(REG_STATUS, rv);
    chk("status", 18'h00092, 18'(rv));
  endtask

  task automatic s_fault;
    word(1'b1, FN_FAULT, 1'b1);
    chk("fault set", 18'h00006, st & 18'h00007);
    push(BTN_FAULT_CLR);
    chk("fault clr", 18'h00002, st & 18'h00007);
    word(1'b1, 6'h3F, 1'b1);
    chk("unknown fn", 18'h00032, st & 18'h0007F);
    word(1'b1, FN_DISABLE_OUTPUT, 1'b1);
    tick(1);
    chk("out off", 18'h00000, st & 18'h000FF);
    word(1'b0, CH_LETTER_A, 1'b0);
    chk("no action", 18'h00000, 18'(tw_action));
  endtask

  task automatic s_input;
    word(1'b1, FN_ENABLE_INPUT, 1'b1);
    tick(1);
    chk("input", 18'h00039, st & 18'h0003F);
    feed(CH_LETTER_A);
    tick(1);
    reg_read(REG_STATUS, rv);
    chk("status full", 18'h000B1, 18'(rv));
    reg_read(REG_IN_CHAR, rv);
    chk("in char", 18'h00018, 18'(rv));
    reg_read(REG_STATUS, rv);
    chk("status read", 18'h00091, 18'(rv));
    feed(MV_STOP_READ);
    tick(2);
    chk("reader stop", 18'h00000, st & 18'h00008);
  endtask

  task automatic s_panel;
    push(BTN_INPUT_CLR);
    chk("in clr", 18'h00000, st & 18'h00003);
    push(BTN_OUTPUT);
    chk("out btn", 18'h00002, st & 18'h00003);
    push(BTN_OUTPUT_CLR);
    chk("out clr", 18'h00000, st & 18'h00003);
    push(BTN_INPUT);
    tick(1);
    chk("in btn", 18'h00009, st & 18'h0000B);
    word(1'b1, FN_FAULT, 1'b1);
    word(1'b1, FN_MASTER_CLEAR, 1'b1);
    chk("mclr fn", 18'h00000, st & 18'h00007);
    word(1'b1, FN_ENABLE_OUTPUT, 1'b1);
    push(BTN_MASTER_CLR);
    chk("mclr btn", 18'h00000, st & 18'h00007);
    // a frozen block must not take a word
    @(posedge clk_sys);
    clk_en <= 1'b0;
    word(1'b1, FN_ENABLE_OUTPUT, 1'b0);
    chk("frozen", 18'h00000, st & 18'h00007);
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask

  task automatic s_motor;
    @(posedge clk_sys);
    tw_busy <= 1'b1;
    tick(2);
    chk("busy motor", 18'h00030, st & 18'h00070);
    @(posedge clk_sys);
    tw_busy <= 1'b0;
    tick(2);
    chk("idle motor", 18'h00000, st & 18'h00070);
    @(posedge clk_sys);
    online_switch_contacts <= 1'b1;
    tick(3);
    chk("offline", 18'h00068, st & 18'h0007F);
    word(1'b1, FN_ENABLE_INPUT, 1'b0);
    chk("offline lamps", 18'h00000, st & 18'h00007);
    @(posedge clk_sys);
    online_switch_contacts <= 1'b0;
    tick(3);
    chk("online", 18'h00000, st & 18'h0007F);
  endtask

  initial begin
    n_fail = 0;
    checks_done = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    online_switch_contacts = 1'b0;
    panel_btn = '0;
    tw_busy = 1'b0;
    tw_in_valid = 1'b0;
    tw_in_code = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(1);
    chk("reset", 18'h00000, st);
    s_output();
    s_fault();
    s_input();
    s_panel();
    s_motor();
    end_of_test();
  end

  // bound on the whole run so a stuck handshake cannot hang it
  initial begin
    repeat (50000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] run time expected below limit seen limit");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
